// ---- src/bcm_params.svh ----
// Constants for the breaker close/open monitor.
// Assumes a 200 MHz system clock; included by the package and the bench.
`ifndef BCM_PARAMS_SVH
`define BCM_PARAMS_SVH

// Register byte offsets on the AHB-Lite slave.
`define BCM_ADDR_CTRL        8'h00
`define BCM_ADDR_OPEN_TMO    8'h04
`define BCM_ADDR_STATUS      8'h08
`define BCM_ADDR_MSB         7
`define BCM_ADDR_LSB         2

// Control register field positions and reset values.
`define BCM_CTRL_EN_BIT      0
`define BCM_CTRL_LIM_LSB     4
`define BCM_CTRL_LIM_MSB     7
`define BCM_EN_RST           1'b1
`define BCM_LIM_RST          4'h5
`define BCM_LIM_MIN          4'h1
`define BCM_LIM_MAX          4'hA

// Open timeout in units of 10 ms: 0.10 s to 5.00 s, default 2.00 s.
`define BCM_TMO_RST          10'h0C8
`define BCM_TMO_MIN          10'h00A
`define BCM_TMO_MAX          10'h1F4

// Status register field positions.
`define BCM_ST_CLOSE_BIT     0
`define BCM_ST_OPEN_BIT      1
`define BCM_ST_REPLY_BIT     2
`define BCM_ST_CNT_LSB       8
`define BCM_ST_CNT_MSB       11
`define BCM_ST_TMR_BIT       12

// Timing: clock in MHz, 10 ms tick and the 5 s clear time.
`define BCM_CLK_MHZ          200
`define BCM_TICK_US          10000
`define BCM_CLEAR_MS         5000
`define BCM_TICK_MS          10

// Logic command variable codes.
`define BCM_LCV_CLOSE        16'h0807
`define BCM_LCV_OPEN         16'h0808

`endif

// ---- src/bcm_pkg.sv ----
// Types shared by the breaker close/open monitor.
// Assumes bcm_params.svh is on the include path.
`include "bcm_params.svh"

package bcm_pkg;

    typedef enum logic [1:0] {
        BCM_HTRANS_IDLE   = 2'h0,
        BCM_HTRANS_BUSY   = 2'h1,
        BCM_HTRANS_NONSEQ = 2'h2,
        BCM_HTRANS_SEQ    = 2'h3
    } bcm_htrans_e;

    typedef enum logic [1:0] {
        BCM_ALARM_CLASS_A = 2'h0,
        BCM_ALARM_CLASS_B = 2'h1
    } bcm_class_e;

    // One alarm report: active flag, class and logic command code.
    typedef struct packed {
        logic       active;
        bcm_class_e aclass;
        logic [15:0] code;
    } bcm_alarm_s;

    typedef enum {
        BCM_OPEN_IDLE,
        BCM_OPEN_TIMING,
        BCM_OPEN_DONE
    } bcm_open_state_e;

endpackage

// ---- src/bcm_monitor.sv ----
// Breaker close/open monitor with an AHB-Lite register slave.
// Assumes breaker pins are asynchronous and one 200 MHz clock runs the block.
//
// Overview of operation
// - Clear attempt counter after the close output is low over five seconds.
// - Clear attempt counter after closed feedback persists over five seconds.
// - Close alarm reports class B with logic command code 08.07.
// - Open sequence starts a timer; reply not energized at expiry raises open alarm.
// - Open alarm reports class B with logic command code 08.08.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps

module bcm_monitor
    import bcm_pkg::*;
#(
    parameter int unsigned CLEAR_TICKS = `BCM_CLEAR_MS / `BCM_TICK_MS,
    parameter int unsigned TICK_CYCLES = `BCM_CLK_MHZ * `BCM_TICK_US
) (
    // Clock and reset.
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    // AHB-Lite slave.
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Breaker side.
    input  wire logic        i_breaker_close_output,
    input  wire logic        i_open_sequence_start,
    input  wire logic        i_breaker_reply_input,
    // Alarm reports.
    output bcm_alarm_s       o_close_failure_alarm,
    output bcm_alarm_s       o_open_failure_alarm
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic       reply;
    logic       close_out;
    logic       open_start;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= {i_breaker_reply_input, i_open_sequence_start, i_breaker_close_output};
            sync_b <= sync_a;
        end
    end

    assign close_out  = sync_b[0];
    assign open_start = sync_b[1];
    assign reply      = sync_b[2];

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic        enable;
    logic [3:0]  close_limit;
    logic [9:0]  open_tmo;
    logic        wr_pend;
    logic [5:0]  pend_idx;
    logic [3:0]  attempt_cnt;
    logic        open_busy;
    logic        close_alarm;
    logic        open_alarm;
    logic        take;

    function automatic logic [9:0] clamp_tmo(input logic [9:0] v);
        return (v < `BCM_TMO_MIN) ? `BCM_TMO_MIN : ((v > `BCM_TMO_MAX) ? `BCM_TMO_MAX : v);
    endfunction

    function automatic logic [3:0] clamp_lim(input logic [3:0] v);
        return (v < `BCM_LIM_MIN) ? `BCM_LIM_MIN : ((v > `BCM_LIM_MAX) ? `BCM_LIM_MAX : v);
    endfunction

    assign take = i_hsel && i_hready && (i_htrans == BCM_HTRANS_NONSEQ);

    // Zero wait states and an OKAY response on every transfer.
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_pend     <= 1'b0;
            pend_idx    <= 6'h00;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            wr_pend     <= take && i_hwrite;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
            if (take) begin
                pend_idx <= i_haddr[`BCM_ADDR_MSB:`BCM_ADDR_LSB];
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            enable      <= `BCM_EN_RST;
            close_limit <= `BCM_LIM_RST;
            open_tmo    <= `BCM_TMO_RST;
        end else if (wr_pend) begin
            if (pend_idx == 6'(`BCM_ADDR_CTRL >> 2)) begin
                enable      <= i_hwdata[`BCM_CTRL_EN_BIT];
                close_limit <= clamp_lim(i_hwdata[`BCM_CTRL_LIM_MSB:`BCM_CTRL_LIM_LSB]);
            end else if (pend_idx == 6'(`BCM_ADDR_OPEN_TMO >> 2)) begin
                open_tmo <= clamp_tmo(i_hwdata[9:0]);
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_hrdata <= 32'h0;
        end else if (take && !i_hwrite) begin
            o_hrdata <= 32'h0;
            case (i_haddr[`BCM_ADDR_MSB:`BCM_ADDR_LSB])
                6'(`BCM_ADDR_CTRL >> 2): begin
                    o_hrdata[`BCM_CTRL_EN_BIT]                 <= enable;
                    o_hrdata[`BCM_CTRL_LIM_MSB:`BCM_CTRL_LIM_LSB] <= close_limit;
                end
                6'(`BCM_ADDR_OPEN_TMO >> 2): begin
                    o_hrdata[9:0] <= open_tmo;
                end
                6'(`BCM_ADDR_STATUS >> 2): begin
                    o_hrdata[`BCM_ST_CLOSE_BIT]                <= close_alarm;
                    o_hrdata[`BCM_ST_OPEN_BIT]                 <= open_alarm;
                    o_hrdata[`BCM_ST_REPLY_BIT]                <= reply;
                    o_hrdata[`BCM_ST_CNT_MSB:`BCM_ST_CNT_LSB]  <= attempt_cnt;
                    o_hrdata[`BCM_ST_TMR_BIT]                  <= open_busy;
                end
                default: begin
                    o_hrdata <= 32'h0;
                end
            endcase
        end
    end

    // ****************************************************************
    // 10 ms tick divider
    // ****************************************************************
    logic [31:0] div_cnt;
    logic        tick;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_cnt <= 32'h0;
            tick    <= 1'b0;
        end else if (div_cnt >= TICK_CYCLES - 1) begin
            div_cnt <= 32'h0;
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 32'h1;
            tick    <= 1'b0;
        end
    end

    // ****************************************************************
    // Close-attempt supervision
    // ****************************************************************
    logic        close_d;
    logic [15:0] off_ticks;
    logic [15:0] fb_ticks;
    logic        clear_cnt;

    // Only a low that still holds clears via the off timer, so a close edge is lost only while the feedback clear holds.
    assign clear_cnt = (!close_out && off_ticks > 16'(CLEAR_TICKS))
                    || (!reply && fb_ticks > 16'(CLEAR_TICKS));

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            off_ticks <= 16'h0;
            fb_ticks  <= 16'h0;
        end else begin
            if (close_out || !enable) begin
                off_ticks <= 16'h0;
            end else if (tick && !clear_cnt) begin
                off_ticks <= off_ticks + 16'h1;
            end
            if (reply || !enable) begin
                fb_ticks <= 16'h0;
            end else if (tick && !clear_cnt) begin
                fb_ticks <= fb_ticks + 16'h1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            close_d     <= 1'b0;
            attempt_cnt <= 4'h0;
            close_alarm <= 1'b0;
        end else begin
            close_d <= close_out;
            if (!enable) begin
                attempt_cnt <= 4'h0;
                close_alarm <= 1'b0;
            end else if (clear_cnt) begin
                attempt_cnt <= 4'h0;
                close_alarm <= 1'b0;
            end else if (close_out && !close_d && attempt_cnt < close_limit) begin
                attempt_cnt <= attempt_cnt + 4'h1;
                close_alarm <= (attempt_cnt + 4'h1) >= close_limit;
            end
        end
    end

    // ****************************************************************
    // Open supervision timer
    // ****************************************************************
    bcm_open_state_e open_state;
    logic [9:0]      open_ticks;

    assign open_busy = (open_state == BCM_OPEN_TIMING);

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            open_state <= BCM_OPEN_IDLE;
            open_ticks <= 10'h0;
            open_alarm <= 1'b0;
        end else if (!enable) begin
            open_state <= BCM_OPEN_IDLE;
            open_ticks <= 10'h0;
            open_alarm <= 1'b0;
        end else begin
            case (open_state)
                BCM_OPEN_IDLE: begin
                    if (open_start) begin
                        open_state <= BCM_OPEN_TIMING;
                        open_ticks <= 10'h0;
                        open_alarm <= 1'b0;
                    end
                end
                BCM_OPEN_TIMING: begin
                    if (reply) begin
                        // Parking in done keeps a start that is still held from rearming.
                        open_state <= BCM_OPEN_DONE;
                    end else if (open_ticks >= open_tmo) begin
                        open_state <= BCM_OPEN_DONE;
                        open_alarm <= 1'b1;
                    end else if (tick) begin
                        open_ticks <= open_ticks + 10'h1;
                    end
                end
                BCM_OPEN_DONE: begin
                    if (!open_start) begin
                        open_state <= BCM_OPEN_IDLE;
                    end
                end
                default: begin
                    open_state <= BCM_OPEN_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Alarm outputs
    // ****************************************************************
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_close_failure_alarm <= '0;
            o_open_failure_alarm  <= '0;
        end else begin
            o_close_failure_alarm <= '{close_alarm, BCM_ALARM_CLASS_B, `BCM_LCV_CLOSE};
            o_open_failure_alarm  <= '{open_alarm, BCM_ALARM_CLASS_B, `BCM_LCV_OPEN};
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_disabled;
        !enable;
    endsequence

    property p_disable_clears;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        s_disabled ##1 1 |-> attempt_cnt == 4'h0 && !open_busy;
    endproperty
    a_disable_clears: assert property (p_disable_clears) else $error("disable kept state");
    property p_disable_outputs;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        !enable [*3] |-> !o_close_failure_alarm.active && !o_open_failure_alarm.active;
    endproperty
    a_disable_outputs: assert property (p_disable_outputs) else $error("alarm while disabled");
    property p_close_limit;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        attempt_cnt <= close_limit;
    endproperty
    a_close_limit: assert property (p_close_limit) else $error("count above limit");
    property p_close_alarm_at_limit;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        $rose(close_alarm) |-> attempt_cnt == close_limit;
    endproperty
    a_close_alarm_at_limit: assert property (p_close_alarm_at_limit) else $error("close alarm early");
    property p_clear;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        enable && clear_cnt |=> attempt_cnt == 4'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("count not cleared");
    property p_close_code;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        close_alarm |=> o_close_failure_alarm.active && o_close_failure_alarm.code == `BCM_LCV_CLOSE
            && o_close_failure_alarm.aclass == BCM_ALARM_CLASS_B;
    endproperty
    a_close_code: assert property (p_close_code) else $error("close report wrong");
    property p_open_code;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        open_alarm |=> o_open_failure_alarm.active && o_open_failure_alarm.code == `BCM_LCV_OPEN
            && o_open_failure_alarm.aclass == BCM_ALARM_CLASS_B;
    endproperty
    a_open_code: assert property (p_open_code) else $error("open report wrong");
    property p_open_timeout;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        $rose(open_alarm) |-> $past(open_ticks) >= open_tmo && !$past(reply);
    endproperty
    a_open_timeout: assert property (p_open_timeout) else $error("open alarm early");
    property p_reply_stops;
        @(posedge i_clk_sys) disable iff (i_sys_rst)
        open_busy && reply && enable |=> !open_busy && !$rose(open_alarm);
    endproperty
    a_reply_stops: assert property (p_reply_stops) else $error("timer kept running");

endmodule

// ---- verif/bcm_breaker_model.sv ----
// Behavioural model of a mains breaker with a close relay and a reply contact.
// Assumes the bench drives the stuck and slow controls off the clock edge.
`timescale 1ns/1ps

module bcm_breaker_model #(
    parameter int unsigned FAST_CYCLES = 2,
    parameter int unsigned SLOW_CYCLES = 40
) (
    // Clock.
    input  wire logic i_clk_sys,
    // Commands from the controller side.
    input  wire logic i_close_cmd,
    input  wire logic i_open_cmd,
    // Fault and speed controls from the bench.
    input  wire logic i_stuck,
    input  wire logic i_slow,
    // Reply contact.
    output logic      o_reply
);
    logic        closed = 1'b0;
    logic        target;
    int unsigned cnt    = 0;

    assign target = i_close_cmd ? 1'b1 : (i_open_cmd ? 1'b0 : closed);

    // A stuck mechanism never moves; otherwise it moves after its travel time.
    always_ff @(posedge i_clk_sys) begin
        if (i_stuck || target == closed) begin
            cnt <= 0;
        end else if (cnt + 1 >= (i_slow ? SLOW_CYCLES : FAST_CYCLES)) begin
            closed <= target;
            cnt    <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end

    // The reply is de-energized while closed and energized while open.
    assign o_reply = ~closed;
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the breaker close/open monitor.
// Assumes short tick and clear parameters so that each scenario is brief.
`timescale 1ns/1ps
`include "bcm_params.svh"
`define CHECK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end

module tb;
    import bcm_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic        hready, hresp, close_cmd = 1'b0, open_cmd = 1'b0, reply;
    logic        stuck = 1'b0, slow = 1'b0;
    bcm_alarm_s  close_alm, open_alm;
    int          miscompares = 0, cmp_count = 0, cycles = 0;
    logic [31:0] rd;

    always #2.5 clk = ~clk;

    bcm_monitor #(.CLEAR_TICKS(5), .TICK_CYCLES(10)) dut (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_breaker_close_output(close_cmd), .i_open_sequence_start(open_cmd),
        .i_breaker_reply_input(reply), .o_close_failure_alarm(close_alm),
        .o_open_failure_alarm(open_alm));

    bcm_breaker_model brk (
        .i_clk_sys(clk), .i_close_cmd(close_cmd), .i_open_cmd(open_cmd),
        .i_stuck(stuck), .i_slow(slow), .o_reply(reply));

    // ****************************************
    // Bus and helper tasks
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= BCM_HTRANS_NONSEQ;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= BCM_HTRANS_IDLE; hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic chk_alarm(input bcm_alarm_s a, input logic act, input logic [15:0] code);
        `CHECK("alarm active", act, a.active)
        `CHECK("alarm class", BCM_ALARM_CLASS_B, a.aclass)
        `CHECK("alarm code", code, a.code)
    endtask

    task automatic pulse_close(input int n);
        repeat (n) begin
            close_cmd <= 1'b1; cyc(5); close_cmd <= 1'b0; cyc(5);
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_values();
        ahb(1'b0, 32'h00, '0); `CHECK("ctrl", 32'h0000_0051, rd)
        ahb(1'b0, 32'h04, '0); `CHECK("timeout", 32'h0000_00C8, rd)
        ahb(1'b0, 32'h08, '0); `CHECK("status", 32'h0000_0004, rd)
        ahb(1'b0, 32'h0C, '0); `CHECK("unmapped", 32'h0000_0000, rd)
        `CHECK("hready", 1'b1, hready) `CHECK("hresp", 1'b0, hresp)
        chk_alarm(close_alm, 1'b0, `BCM_LCV_CLOSE);
        chk_alarm(open_alm, 1'b0, `BCM_LCV_OPEN);
    endtask

    task automatic t_feedback_clear();
        close_cmd <= 1'b1; cyc(20);
        ahb(1'b0, 32'h08, '0); `CHECK("count one", 4'h1, rd[11:8])
        cyc(100);
        ahb(1'b0, 32'h08, '0); `CHECK("count fb clear", 4'h0, rd[11:8])
        close_cmd <= 1'b0; cyc(5);
    endtask

    task automatic t_open_fail();
        ahb(1'b1, 32'h04, 32'h0000_000A);
        close_cmd <= 1'b1; cyc(10);
        stuck <= 1'b1; close_cmd <= 1'b0; open_cmd <= 1'b1; cyc(60);
        ahb(1'b0, 32'h08, '0); `CHECK("timer run", 1'b1, rd[12])
        chk_alarm(open_alm, 1'b0, `BCM_LCV_OPEN);
        cyc(80);
        chk_alarm(open_alm, 1'b1, `BCM_LCV_OPEN);
    endtask

    task automatic t_disable();
        ahb(1'b1, 32'h00, 32'h0000_0050); cyc(3);
        chk_alarm(open_alm, 1'b0, `BCM_LCV_OPEN);
        pulse_close(2);
        ahb(1'b0, 32'h08, '0); `CHECK("status off", 32'h0000_0000, rd & 32'h1F03)
        chk_alarm(close_alm, 1'b0, `BCM_LCV_CLOSE);
        open_cmd <= 1'b0;
        ahb(1'b1, 32'h00, 32'h0000_0051);
    endtask

    task automatic t_open_ok();
        open_cmd <= 1'b0; stuck <= 1'b0; slow <= 1'b1; cyc(10);
        open_cmd <= 1'b1; cyc(20);
        ahb(1'b0, 32'h08, '0); `CHECK("timer start", 1'b1, rd[12])
        cyc(130);
        ahb(1'b0, 32'h08, '0); `CHECK("timer stop", 1'b0, rd[12])
        chk_alarm(open_alm, 1'b0, `BCM_LCV_OPEN);
        open_cmd <= 1'b0; cyc(5);
    endtask

    task automatic t_close_fail();
        stuck <= 1'b1;
        ahb(1'b1, 32'h00, 32'h0000_0021);
        pulse_close(1);
        chk_alarm(close_alm, 1'b0, `BCM_LCV_CLOSE);
        pulse_close(1);
        chk_alarm(close_alm, 1'b1, `BCM_LCV_CLOSE);
        ahb(1'b0, 32'h08, '0); `CHECK("count two", 4'h2, rd[11:8])
        cyc(100);
        ahb(1'b0, 32'h08, '0); `CHECK("count cmd clear", 4'h0, rd[11:8])
        chk_alarm(close_alm, 1'b0, `BCM_LCV_CLOSE);
    endtask

    // ****************************************
    // Closing report and main sequence
    // ****************************************
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        cyc(5);
        rst <= 1'b0;
        t_reset_values();
        t_feedback_clear();
        t_open_fail();
        t_disable();
        t_open_ok();
        t_close_fail();
        report_and_stop();
    end
endmodule
